// ===== inc/buck_pkg.sv
// Shared constants, types and register map of the buck supervisor
package buck_pkg;

  // ************************************************************
  // Clock and timing
  // ************************************************************
  localparam int CLK_HZ      = 10_000_000;
  localparam int SS_TIME_US  = 2800;  // Soft-start duration
  localparam int SS_CYCLES   = (SS_TIME_US * (CLK_HZ / 1000)) / 1000;
  localparam int TON_MIN_NS  = 25;    // Least controllable on-time
  localparam int SS_CLAMP_MV = 150;   // Clamp height above feedback
  localparam int FB_HIC_MV   = 400;   // Hiccup feedback threshold
  localparam int OVL_TERM    = 512;
  localparam int HIC_WAIT    = 16384;
  localparam int CLAMP_EVTS  = 16;
  localparam int QUIET_CYC   = 4;
  localparam int SS_BITS     = 10;

  // ************************************************************
  // Register map (byte addresses)
  // ************************************************************
  localparam logic [4:0] ADDR_CTRL   = 5'h00;
  localparam logic [4:0] ADDR_STATUS = 5'h04;
  localparam logic [4:0] ADDR_MASK   = 5'h08;
  localparam logic [4:0] ADDR_CONFIG = 5'h0C;
  localparam logic [4:0] ADDR_STATE  = 5'h10;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  localparam int CTRL_SYNC_ALLOW = 0;   // External clock allowed
  localparam int CTRL_HIC_OFF    = 1;   // Hiccup protection off
  localparam int EVT_BITS   = 5;
  localparam int EVT_CL     = 0;
  localparam int EVT_HICCUP = 1;
  localparam int EVT_SSDONE = 2;
  localparam int EVT_CLAMP  = 3;
  localparam int EVT_SKIP   = 4;

  // ************************************************************
  // Strap codes and decoded configuration
  // ************************************************************
  typedef enum logic [1:0] {
    OUTPUT_NODE_3V3, OUTPUT_NODE_5V0, OUTPUT_NODE_12V, OUTPUT_NODE_ADJ
  } output_node_e;

  typedef enum logic [1:0] {
    MODE_STANDALONE, MODE_PRIMARY, MODE_SECONDARY
  } mode_e;

  localparam logic [2:0] CFG_29K4 = 3'h0;
  localparam logic [2:0] CFG_41K2 = 3'h1;
  localparam logic [2:0] CFG_54K9 = 3'h2;
  localparam logic [2:0] CFG_71K5 = 3'h3;
  localparam logic [2:0] CFG_90K9 = 3'h4;

  typedef struct packed {
    output_node_e output_node;
    logic  bias_8v;
    logic  comp_int;
    mode_e mode;
    logic  spread;
  } strap_cfg_s;

endpackage : buck_pkg

// ===== rtl/buck_supervisor.sv
// Buck converter supervisor: straps, soft-start, limits, registers
//
// The address map and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module buck_supervisor
  import buck_pkg::*;
#(
  parameter int SS_CYC  = SS_CYCLES,
  parameter int HIC_CYC = HIC_WAIT
) (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               resetn,
  // Avalon-MM slave
  input  wire logic [4:0]         address,
  input  wire logic               read,
  input  wire logic               write,
  input  wire logic [31:0]        writedata,
  output logic [31:0]             readdata,
  output logic                    waitrequest,
  output logic                    irq,
  // Analog and pin inputs, asynchronous
  input  wire logic               en_pin,
  input  wire logic               vcc_uvlo,
  input  wire logic               osc_tick,
  input  wire logic               ext_sync_in,
  input  wire logic               current_sense_input,
  input  wire logic               fb_above_400mv,
  input  wire logic [1:0]         feedback_pin,
  input  wire logic               compensation_pin,
  input  wire logic [2:0]         config_strap,
  // Loop request, same clock
  input  wire logic               pwm_on,
  input  wire logic [15:0]        ton_req_ns,
  // Drive and status outputs
  output logic                    hs_drive,
  output logic                    ls_enable,
  output logic [SS_BITS-1:0]      ss_level,
  output logic                    ss_clamp_en,
  output logic                    osc_ext_sel,
  output strap_cfg_s              cfg,
  output logic                    power_good_output,
  output logic                    power_good_oe
);

  localparam int SS_STEP = (SS_CYC >> SS_BITS) + 1;

  // ************************************************************
  // Input synchronisers
  // ************************************************************
  localparam int NS = 12;
  logic [NS-1:0] pin_raw;
  logic [NS-1:0] meta_reg;
  logic [NS-1:0] sync_reg;
  logic          tick_d_reg;
  logic          en_d_reg;

  assign pin_raw = {en_pin, vcc_uvlo, osc_tick, ext_sync_in,
                    current_sense_input, fb_above_400mv,
                    feedback_pin, compensation_pin, config_strap};

  // Two stages before any logic sees a pin
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta_reg   <= '0;
      sync_reg   <= '0;
      tick_d_reg <= 1'b0;
      en_d_reg   <= 1'b0;
    end else begin
      meta_reg   <= pin_raw;
      sync_reg   <= meta_reg;
      tick_d_reg <= sync_reg[9];
      en_d_reg   <= sync_reg[11];
    end
  end

  logic       en_s, uvlo_s, tick_s, xsync_s, cl_s, fb_s, comp_s;
  logic [1:0] fbstrap_s;
  logic [2:0] cfgstrap_s;
  logic       cyc, en_rise, run;

  assign en_s       = sync_reg[11];
  assign uvlo_s     = sync_reg[10];
  assign tick_s     = sync_reg[9];
  assign xsync_s    = sync_reg[8];
  assign cl_s       = sync_reg[7];
  assign fb_s       = sync_reg[6];
  assign fbstrap_s  = sync_reg[5:4];
  assign comp_s     = sync_reg[3];
  assign cfgstrap_s = sync_reg[2:0];
  assign cyc        = tick_s && !tick_d_reg;   // Switching cycle start
  assign en_rise    = en_s && !en_d_reg;
  assign run        = en_s && !uvlo_s;

  // ************************************************************
  // Strap decode
  // ************************************************************
  function automatic mode_e mode_of(input logic [2:0] c);
    case (c)
      CFG_54K9, CFG_71K5: mode_of = MODE_PRIMARY;
      CFG_90K9:           mode_of = MODE_SECONDARY;
      default:            mode_of = MODE_STANDALONE;
    endcase
  endfunction : mode_of

  function automatic logic spread_of(input logic [2:0] c);
    spread_of = (c == CFG_41K2) || (c == CFG_71K5);
  endfunction : spread_of

  // ************************************************************
  // Strap latching
  // ************************************************************
  logic output_node_done_reg;
  logic comp_arm_reg;
  logic cfg_done_reg;

  // Voltage once per power-up; comp needs UVLO; config on enable
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      output_node_done_reg <= 1'b0;
      comp_arm_reg  <= 1'b1;
      cfg_done_reg  <= 1'b0;
      cfg           <= '0;
    end else begin
      if (uvlo_s) comp_arm_reg <= 1'b1;
      if (en_rise) cfg_done_reg <= 1'b0;
      if (run && !output_node_done_reg) begin
        output_node_done_reg <= 1'b1;
        cfg.output_node      <= output_node_e'(fbstrap_s);
        cfg.bias_8v   <= fbstrap_s[1];
      end
      if (run && comp_arm_reg) begin
        comp_arm_reg <= 1'b0;
        cfg.comp_int <= comp_s;
      end
      if (run && !cfg_done_reg) begin
        cfg_done_reg <= 1'b1;
        cfg.mode     <= mode_of(cfgstrap_s);
        cfg.spread   <= spread_of(cfgstrap_s);
      end
    end
  end

  // ************************************************************
  // Register file
  // ************************************************************
  logic [31:0]          ctrl_reg;
  logic [EVT_BITS-1:0]  status_reg;
  logic [EVT_BITS-1:0]  mask_reg;
  logic [EVT_BITS-1:0]  evt;
  logic                 ack_reg;
  logic                 wr_go;
  logic                 hiccup, hic_start, clamp;
  logic [15:0]          ovl_count;

  // One wait state: simple and keeps readdata registered
  assign waitrequest = (read || write) && !ack_reg;
  assign wr_go       = write && ack_reg;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) ack_reg <= 1'b0;
    else ack_reg <= (read || write) && !ack_reg;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_reg <= CTRL_RESET;
      mask_reg <= '0;
    end else if (wr_go) begin
      if (address == ADDR_CTRL) ctrl_reg <= {30'h0, writedata[1:0]};
      if (address == ADDR_MASK) mask_reg <= writedata[EVT_BITS-1:0];
    end
  end

  // Sticky events; a new event beats a write-one clear
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) status_reg <= '0;
    else if (wr_go && address == ADDR_STATUS)
      status_reg <= (status_reg & ~writedata[EVT_BITS-1:0]) | evt;
    else status_reg <= status_reg | evt;
  end

  assign irq = |(status_reg & mask_reg);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) readdata <= 32'h0000_0000;
    else if (read && !ack_reg) begin
      case (address)
        ADDR_CTRL:   readdata <= ctrl_reg;
        ADDR_STATUS: readdata <= 32'(status_reg);
        ADDR_MASK:   readdata <= 32'(mask_reg);
        ADDR_CONFIG: readdata <= 32'(cfg);
        ADDR_STATE:  readdata <= {14'h0, hiccup, clamp, ovl_count};
        default:     readdata <= 32'h0000_0000;
      endcase
    end
  end

  // ************************************************************
  // Soft-start ramp
  // ************************************************************
  logic [15:0]        step_reg;
  logic               ss_done;
  logic               ss_done_d_reg;

  assign ss_done = &ss_level;

  // Held low while disabled or in hiccup wait
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ss_level <= '0;
      step_reg <= 16'h0000;
    end else if (!run || hiccup) begin
      ss_level <= '0;
      step_reg <= 16'h0000;
    end else if (!ss_done) begin
      if (step_reg == 16'(SS_STEP - 1)) begin
        step_reg <= 16'h0000;
        ss_level <= ss_level + SS_BITS'(1);
      end else begin
        step_reg <= step_reg + 16'h0001;
      end
    end
  end

  // ************************************************************
  // Cycle-by-cycle limit and pulse skipping
  // ************************************************************
  logic cl_seen_reg;
  logic cl_cut_reg;
  logic skip_reg;
  logic too_short;

  assign too_short = ton_req_ns < 16'(TON_MIN_NS);

  // Trip latched for the cycle; set beats the cycle-start clear
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cl_seen_reg <= 1'b0;
      cl_cut_reg  <= 1'b0;
      skip_reg    <= 1'b0;
    end else begin
      if (cl_s) cl_seen_reg <= 1'b1;
      else if (cyc) cl_seen_reg <= 1'b0;
      if (cl_s) cl_cut_reg <= 1'b1;
      else if (cyc) cl_cut_reg <= 1'b0;
      if (cyc) skip_reg <= too_short;
    end
  end

  // Both drivers off in hiccup; high side also off on a trip or a skipped pulse
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hs_drive  <= 1'b0;
      ls_enable <= 1'b0;
    end else begin
      hs_drive  <= run && !hiccup && pwm_on && !cl_s
                   && !cl_cut_reg && !skip_reg;
      ls_enable <= run && !hiccup;
    end
  end

  overload_hiccup #(
    .TERM  (OVL_TERM),
    .WAIT  (HIC_CYC),
    .CLAMP (CLAMP_EVTS)
  ) u_hiccup (
    .clk       (clk),
    .resetn    (resetn),
    .cyc       (cyc),
    .cl_cycle  (cl_seen_reg),
    .ss_done   (ss_done),
    .fb_above  (fb_s),
    .hic_off   (ctrl_reg[CTRL_HIC_OFF]),
    .hiccup    (hiccup),
    .hic_start (hic_start),
    .clamp_en  (clamp),
    .ovl_count (ovl_count)
  );

  assign ss_clamp_en = clamp;

  // ************************************************************
  // Event capture
  // ************************************************************
  logic clamp_d_reg;
  logic skip_d_reg;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ss_done_d_reg <= 1'b0;
      clamp_d_reg   <= 1'b0;
      skip_d_reg    <= 1'b0;
    end else begin
      ss_done_d_reg <= ss_done;
      clamp_d_reg   <= clamp;
      skip_d_reg    <= skip_reg;
    end
  end

  always_comb begin
    evt             = '0;
    evt[EVT_CL]     = cyc && cl_seen_reg;
    evt[EVT_HICCUP] = hic_start;
    evt[EVT_SSDONE] = ss_done && !ss_done_d_reg;
    evt[EVT_CLAMP]  = clamp && !clamp_d_reg;
    evt[EVT_SKIP]   = skip_reg && !skip_d_reg;
  end

  // ************************************************************
  // Clock source and primary sync output
  // ************************************************************
  logic [15:0] per_cnt_reg;
  logic [15:0] period_reg;
  logic        sync_out_reg;

  // Spreading always wins over an external clock
  assign osc_ext_sel = ctrl_reg[CTRL_SYNC_ALLOW] && !cfg.spread
                       && xsync_s;

  // Half-period lag taken from the last measured period
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      per_cnt_reg  <= 16'h0000;
      period_reg   <= 16'h0000;
      sync_out_reg <= 1'b0;
    end else if (cyc) begin
      per_cnt_reg  <= 16'h0000;
      period_reg   <= per_cnt_reg;
      sync_out_reg <= 1'b0;
    end else begin
      if (per_cnt_reg != 16'hFFFF)
        per_cnt_reg <= per_cnt_reg + 16'h0001;
      if (per_cnt_reg == {1'b0, period_reg[15:1]})
        sync_out_reg <= 1'b1;
    end
  end

  // Open-drain pulldown normally; pushed clock when primary
  always_comb begin
    if (cfg.mode == MODE_PRIMARY) begin
      power_good_output = sync_out_reg;
      power_good_oe     = 1'b1;
    end else begin
      power_good_output = 1'b0;
      power_good_oe     = !(run && ss_done);
    end
  end

endmodule : buck_supervisor

// ===== rtl/overload_hiccup.sv
// Overload counting, soft-start clamp enable and hiccup wait
`timescale 1ns/1ps
module overload_hiccup
  import buck_pkg::*;
#(
  parameter int TERM  = OVL_TERM,
  parameter int WAIT  = HIC_WAIT,
  parameter int CLAMP = CLAMP_EVTS
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // Per switching cycle
  input  wire logic        cyc,
  input  wire logic        cl_cycle,
  input  wire logic        ss_done,
  input  wire logic        fb_above,
  input  wire logic        hic_off,
  // Results
  output logic             hiccup,
  output logic             hic_start,
  output logic             clamp_en,
  output logic [15:0]      ovl_count
);

  typedef enum logic [1:0] {ST_WAIT, ST_COUNT, ST_HICCUP} hic_e;
  hic_e        state_reg;
  logic [15:0] wait_reg;
  logic [4:0]  clamp_reg;
  logic [2:0]  quiet_reg;
  logic        quiet;

  assign quiet = (quiet_reg == 3'(QUIET_CYC - 1)) && !cl_cycle;

  // ************************************************************
  // Quiet-cycle and clamp event counters
  // ************************************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      quiet_reg <= 3'h0;
      clamp_reg <= 5'h00;
    end else if (cyc) begin
      if (cl_cycle) quiet_reg <= 3'h0;
      else if (!quiet) quiet_reg <= quiet_reg + 3'h1;
      if (quiet) clamp_reg <= 5'h00;
      else if (cl_cycle && clamp_reg != 5'(CLAMP))
        clamp_reg <= clamp_reg + 5'h01;
    end
  end

  // Clamp only once enough events stacked up
  assign clamp_en = (clamp_reg == 5'(CLAMP)) && !hiccup;

  // ************************************************************
  // Hiccup state machine
  // ************************************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= ST_WAIT;
      ovl_count <= 16'h0000;
      wait_reg  <= 16'h0000;
      hic_start <= 1'b0;
    end else begin
      hic_start <= 1'b0;
      case (state_reg)
        ST_WAIT: begin
          ovl_count <= 16'h0000;
          if (ss_done && fb_above && !hic_off)
            state_reg <= ST_COUNT;
        end
        ST_COUNT: begin
          if (hic_off || !ss_done) begin
            state_reg <= ST_WAIT;
          end else if (cyc) begin
            if (quiet) ovl_count <= 16'h0000;
            else if (cl_cycle) begin
              if (ovl_count == 16'(TERM - 1)) begin
                ovl_count <= 16'h0000;
                if (!fb_above) begin
                  state_reg <= ST_HICCUP;
                  wait_reg  <= 16'h0000;
                  hic_start <= 1'b1;
                end
              end else begin
                ovl_count <= ovl_count + 16'h0001;
              end
            end
          end
        end
        ST_HICCUP: begin
          if (cyc) begin
            if (wait_reg == 16'(WAIT - 1))
              state_reg <= ST_WAIT;
            else wait_reg <= wait_reg + 16'h0001;
          end
        end
        default: state_reg <= ST_WAIT;
      endcase
    end
  end

  assign hiccup = (state_reg == ST_HICCUP);

endmodule : overload_hiccup

// ===== verif/buck_supervisor_assertions.sv
// Port-level assertions for the buck supervisor
`timescale 1ns/1ps
module buck_supervisor_assertions
  import buck_pkg::*;
(
  // Clock and reset
  input wire logic               clk,
  input wire logic               resetn,
  // Watched ports
  input wire logic               current_sense_input,
  input wire logic [15:0]        ton_req_ns,
  input wire logic               hs_drive,
  input wire logic               ls_enable,
  input wire logic [SS_BITS-1:0] ss_level,
  input wire logic               osc_ext_sel,
  input wire strap_cfg_s         cfg,
  input wire logic               power_good_oe,
  input wire logic               ss_clamp_en
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // ************************************************************
  // Properties
  // ************************************************************
  property p_cut;
    current_sense_input [*4] |-> !hs_drive;
  endproperty
  property p_skip;
    (ton_req_ns < 16'(TON_MIN_NS)) [*8] |-> !hs_drive;
  endproperty
  property p_spread;
    cfg.spread |-> !osc_ext_sel;
  endproperty
  property p_sync;
    cfg.mode == MODE_PRIMARY |-> power_good_oe;
  endproperty
  property p_output_node;
    &ss_level |=> $stable(cfg.output_node);
  endproperty
  property p_comp;
    &ss_level ##1 &ss_level |-> $stable(cfg.comp_int);
  endproperty
  property p_cfg;
    &ss_level |=> $stable(cfg.mode) && $stable(cfg.spread);
  endproperty
  // The ramp clears on the same edge as the driver; the second cycle is only margin
  property p_hic;
    !ls_enable [*2] |-> ss_level == '0;
  endproperty

  a_cut: assert property (p_cut) else $error("pulse kept on trip");
  a_skip: assert property (p_skip) else $error("short pulse driven");
  a_spread: assert property (p_spread) else $error("sync followed");
  a_sync: assert property (p_sync) else $error("sync pin not driven");
  a_output_node: assert property (p_output_node) else $error("output_node changed");
  a_comp: assert property (p_comp) else $error("comp changed");
  a_cfg: assert property (p_cfg) else $error("mode changed");
  a_hic: assert property (p_hic) else $error("ramp not held low");

  c_hic: cover property ($fell(ls_enable));
  c_clamp: cover property ($rose(ss_clamp_en));
  c_done: cover property ($rose(&ss_level));
endmodule : buck_supervisor_assertions

// ===== verif/strap_model.sv
// Strap resistors, oscillator and load seen by the supervisor
`timescale 1ns/1ps
module strap_model (
  // Clock
  input  wire logic       clk,
  // Chosen straps and load
  input  wire logic [2:0] pick,
  input  wire logic       overload,
  // Pins toward the supervisor
  output logic            osc_tick,
  output logic [1:0]      fb_strap,
  output logic            comp_strap,
  output logic [2:0]      cfg_strap,
  output logic            trip
);
  logic [1:0] div_reg = 2'h0;
  // Four-clock oscillator keeps a switching cycle short
  always_ff @(posedge clk) begin
    div_reg <= div_reg + 2'h1;
  end
  // Resistors are static, so straps follow the pick directly
  assign osc_tick   = div_reg[1];
  assign fb_strap   = pick[1:0];
  assign comp_strap = pick[0];
  assign cfg_strap  = pick;
  assign trip       = overload;  // Comparator tracks the load
endmodule : strap_model

// ===== verif/test_buck_protect_config_sequencer.sv
// Self-checking bench for the buck supervisor
`timescale 1ns/1ps
module test_buck_protect_config_sequencer
  import buck_pkg::*;
;
  logic               clk = 1'b0;
  logic               resetn = 1'b0;
  logic [4:0]         address = 5'h00;
  logic               read = 1'b0;
  logic               write = 1'b0;
  logic [31:0]        writedata = 32'h0;
  logic [31:0]        readdata, d;
  logic               waitrequest, irq, osc, trip, comp, hs, ls;
  logic               en_pin = 1'b1;
  logic               vcc_uvlo = 1'b0;
  logic               fb_ok = 1'b1;
  logic               xsync = 1'b1;
  logic               overload = 1'b0;
  logic               clamp, ext_sel, pg, pg_oe;
  logic [1:0]         fb;
  logic [2:0]         pick = 3'h0;
  logic [2:0]         cs;
  logic [6:0]         e;
  logic [15:0]        ton = 16'h0064;
  logic [SS_BITS-1:0] ss;
  strap_cfg_s         cfg;
  int                 bad_count = 0;
  int                 checks = 0;
  int                 cyc_n = 0;
  int                 n;

  // ************************************************************
  // Clock, timeout and instances
  // ************************************************************
  initial forever #50 clk = ~clk;
  always @(posedge clk) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 40000) begin
      bad_count++;
      results();
    end
  end
  strap_model part_u (.clk(clk), .pick(pick), .overload(overload),
    .osc_tick(osc), .fb_strap(fb), .comp_strap(comp), .cfg_strap(cs),
    .trip(trip));
  // Short counts keep the run brief
  buck_supervisor #(.SS_CYC(1024), .HIC_CYC(8)) dut_u (.clk(clk),
    .resetn(resetn), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .irq(irq), .en_pin(en_pin), .vcc_uvlo(vcc_uvlo), .osc_tick(osc),
    .ext_sync_in(xsync), .current_sense_input(trip), .fb_above_400mv(fb_ok),
    .feedback_pin(fb), .compensation_pin(comp), .config_strap(cs),
    .pwm_on(1'b1), .ton_req_ns(ton), .hs_drive(hs), .ls_enable(ls),
    .ss_level(ss), .ss_clamp_en(clamp), .osc_ext_sel(ext_sel), .cfg(cfg),
    .power_good_output(pg), .power_good_oe(pg_oe));

  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %h not %h", $time, seen, exp);
    end
  endtask : chk
  task automatic tick(input int c);
    repeat (c) @(posedge clk);
  endtask : tick
  // Holds the request until waitrequest is seen low
  task automatic bus(input logic wr, input logic [4:0] a, input int w);
    int k;
    k = 0;
    @(posedge clk);
    address   <= a;
    writedata <= w;
    read      <= !wr;
    write     <= wr;
    do begin
      @(posedge clk);
      k++;
    end while (waitrequest !== 1'b0 && k < 50);
    if (waitrequest !== 1'b0) bad_count++;
    d = readdata;
    read  <= 1'b0;
    write <= 1'b0;
  endtask : bus
  task automatic do_reset;
    resetn <= 1'b0;
    tick(12);
    resetn <= 1'b1;
    tick(12);
  endtask : do_reset
  task automatic wait_ss;
    n = 0;
    while (ss !== '1 && n < 20000) begin
      @(negedge clk);
      n++;
    end
  endtask : wait_ss
  // Expected strap decode: output_node, bias, comp, mode, spread
  function automatic logic [6:0] exp_cfg(input int p);
    int v, m;
    v = p % 4;
    m = (p == 4) ? 2 : (p == 2 || p == 3) ? 1 : 0;
    return {v[1:0], v >= 2, p % 2 == 1, m[1:0], p == 1 || p == 3};
  endfunction : exp_cfg
  task automatic results;
    $display("checks %0d, mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : results

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    void'($urandom(37834));
    do_reset();
    bus(0, ADDR_CTRL, 0);
    chk(d, CTRL_RESET);
    bus(0, 5'h14, 0);
    chk(d, 32'h0);
    $display("registers done");
    // Every strap code, then a strap change that must not stick
    for (int i = 0; i < 8; i++) begin
      pick  <= 3'(i);
      xsync <= 1'($urandom_range(1));
      e = exp_cfg(i);
      do_reset();
      bus(0, ADDR_CONFIG, 0);
      chk(d, {25'h0, e});
      chk(32'(cfg), 32'(e));
      chk(ext_sel, xsync && !e[0]);
      if (e[2:1] == 2'h1) chk(pg_oe, 1);
      // Sync clock is high for half of each switching cycle
      n = 0;
      repeat (8) @(negedge clk) if (pg !== 1'b0) n++;
      chk(n, (e[2:1] == 2'h1) ? 4 : 0);
      tick(1);
      pick <= 3'($urandom_range(7));
      tick(8);
      bus(0, ADDR_CONFIG, 0);
      chk(d, {25'h0, e});
    end
    // Enable toggle relatches mode and spread only; undervoltage relatches comp
    en_pin <= 1'b0;
    tick(6);
    pick   <= 3'h2;
    en_pin <= 1'b1;
    tick(10);
    bus(0, ADDR_CONFIG, 0);
    chk(d[6:0], 7'h7A);
    vcc_uvlo <= 1'b1;
    tick(6);
    vcc_uvlo <= 1'b0;
    tick(10);
    bus(0, ADDR_CONFIG, 0);
    chk(d[6:0], 7'h72);
    $display("straps done");
    bus(1, ADDR_MASK, 32'h4);
    bus(1, ADDR_STATUS, 32'h1F);
    wait_ss();
    chk(&ss, 1);
    tick(3);
    chk(irq, 1);
    bus(1, ADDR_STATUS, 32'h4);
    tick(2);
    chk(irq, 0);
    $display("soft-start done");
    // Clamp after sixteen limited cycles, cleared by quiet cycles
    overload <= 1'b1;
    tick(40);
    bus(0, ADDR_STATE, 0);
    chk(d[16], 0);
    tick(48);
    bus(0, ADDR_STATE, 0);
    chk(d[16], 1);
    chk(clamp, 1);
    overload <= 1'b0;
    tick(30);
    bus(0, ADDR_STATE, 0);
    chk(d[16:0], 0);
    chk(clamp, 0);
    overload <= 1'b1;
    tick(400);
    bus(0, ADDR_STATE, 0);
    chk(d[15:0] > 16'h005A && d[15:0] < 16'h0066, 1);
    n = 0;
    repeat (2400) begin
      @(negedge clk);
      if (ls !== 1'b1) n++;
    end
    chk(n, 0);
    // Low feedback at terminal count forces a hiccup
    @(posedge clk);
    fb_ok <= 1'b0;
    n = 0;
    while (ls === 1'b1 && n < 2200) begin
      @(negedge clk);
      n++;
    end
    chk(ss, 0);
    chk(hs, 0);
    n = 0;
    while (ls !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    chk(n > 24 && n < 44, 1);
    @(posedge clk);
    overload <= 1'b0;
    $display("overload done");
    wait_ss();
    tick(1);
    ton <= 16'($urandom_range(24));
    tick(8);
    n = 0;
    repeat (40) begin
      @(negedge clk);
      if (hs !== 1'b0) n++;
    end
    chk(n, 0);
    bus(0, ADDR_STATUS, 0);
    chk(d[4], 1);
    ton <= 16'(25 + $urandom_range(975));
    n = 0;
    while (hs !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    chk(n < 40, 1);
    $display("pulse skip done");
    results();
  end
endmodule : test_buck_protect_config_sequencer

bind buck_supervisor buck_supervisor_assertions chk_u (.clk(clk),
  .resetn(resetn), .current_sense_input(current_sense_input),
  .ton_req_ns(ton_req_ns), .hs_drive(hs_drive), .ls_enable(ls_enable),
  .ss_level(ss_level), .osc_ext_sel(osc_ext_sel), .cfg(cfg),
  .power_good_oe(power_good_oe), .ss_clamp_en(ss_clamp_en));
